// [core/upra_arbiter.v]
// upra_arbiter.v: upstream read arbitration of the serial control channel
// ==========================================================
// Summary of operation
// - start single-read upstream reply within response time (multi-read preparation exceeds it)
// - discard reads while upstream transfer runs
// - accept read only after last stop bit or after a stop command
// - data frames always processed, never blocked
// - ignore writes during preparation interval
// - execute writes after preparation, even mid-transfer
// - send register value held before write
// - stop command aborts and clears pending reads
// - response timed from select rise to start
// - flag read discarded during multi-read with overflow bit
// - busy bit high until last frame
`timescale 1ns/100ps
`include "upra_consts.vh"
module upra_arbiter (
    mclk,
    rst,
    frame_select_n,
    link_clock_pos,
    cmd_valid,
    cmd_is_read,
    cmd_multi,
    cmd_reg_idx,
    cmd_frames,
    cmd_is_stop,
    cmd_data,
    data_valid,
    reg_wr_data,
    write_exec,
    data_exec,
    read_reject,
    upstream_out,
    upstream_oe_n,
    upstream_active,
    read_overflow_flag,
    read_busy_flag,
    rsp_timeout
);
    input wire mclk;
    input wire rst;
    input wire frame_select_n;
    input wire link_clock_pos;
    input wire cmd_valid;
    input wire cmd_is_read;
    input wire cmd_multi;
    input wire [`UPRA_REG_IDX_W-1:0] cmd_reg_idx;
    input wire [3:0] cmd_frames;
    input wire cmd_is_stop;
    input wire [`UPRA_DATA_W-1:0] cmd_data;
    input wire data_valid;
    input wire [`UPRA_DATA_W-1:0] reg_wr_data;
    output wire write_exec;
    output wire data_exec;
    output wire read_reject;
    output reg upstream_out;
    output wire upstream_oe_n;
    output wire upstream_active;
    output reg read_overflow_flag;
    output wire read_busy_flag;
    output reg rsp_timeout;

    localparam ST_IDLE = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_LOAD = 4'b0100;
    localparam ST_SHIFT = 4'b1000;

    // ==========================================================
    // pin synchronisers and edge detection
    reg [1:0] fsel_sync_q;
    reg [1:0] clk_sync_q;
    reg fsel_last_q;
    reg clk_last_q;
    wire fsel_rise;
    wire link_edge;

    always @(posedge mclk) begin
        if (rst) begin
            fsel_sync_q <= 2'b11;
            clk_sync_q <= 2'b00;
            fsel_last_q <= 1'b1;
            clk_last_q <= 1'b0;
        end else begin
            fsel_sync_q <= {fsel_sync_q[0], frame_select_n};
            clk_sync_q <= {clk_sync_q[0], link_clock_pos};
            fsel_last_q <= fsel_sync_q[1];
            clk_last_q <= clk_sync_q[1];
        end
    end
    assign fsel_rise = fsel_sync_q[1] & ~fsel_last_q;
    assign link_edge = clk_sync_q[1] & ~clk_last_q;

    // ==========================================================
    // arbitration state
    reg [3:0] state_q;
    reg active_q;
    reg multi_q;
    reg [3:0] frames_left_q;
    reg [`UPRA_REG_IDX_W-1:0] idx_q;
    reg [`UPRA_DIV_W-1:0] prep_q;
    reg [`UPRA_DIV_W-1:0] div_q;
    reg [`UPRA_BIT_CNT_W-1:0] bit_q;
    reg [`UPRA_FRAME_BITS-1:0] shreg_q;
    reg [7:0] rsp_cnt_q;
    reg ovf_pend_q;
    wire [`UPRA_DATA_W-1:0] snap_data;
    wire read_cmd;
    wire stop_cmd;
    wire accept_read;
    wire in_prep;
    wire bit_tick;
    wire last_frame;
    wire parity;

    assign read_cmd = cmd_valid & cmd_is_read & fsel_rise;
    assign stop_cmd = cmd_valid & cmd_is_stop & fsel_rise & cmd_data[`UPRA_STOP_BIT];
    assign accept_read = read_cmd & ~active_q;
    assign read_reject = read_cmd & active_q;
    assign in_prep = (state_q == ST_WAIT);
    // writes dropped only during preparation, allowed otherwise
    assign write_exec = cmd_valid & ~cmd_is_read & ~cmd_is_stop & fsel_rise
                        & ~in_prep;
    assign data_exec = data_valid;
    assign upstream_active = active_q;
    assign upstream_oe_n = ~(state_q == ST_SHIFT);
    assign bit_tick = link_edge && div_q == `UPRA_BIT_DIV - 8'h01;
    assign last_frame = (frames_left_q == 4'h0);
    assign read_busy_flag = multi_q & ~last_frame;
    assign parity = ^snap_data;

    // snapshot taken at load time, so later writes keep the old value
    upra_snap_mem upra_snap_mem_inst (
        .mclk(mclk),
        .rst(rst),
        .wr_en(write_exec),
        .wr_idx(cmd_reg_idx),
        .wr_data(reg_wr_data),
        .rd_en(state_q == ST_WAIT),
        .rd_idx(idx_q),
        .rd_data(snap_data)
    );

    always @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            active_q <= 1'b0;
            multi_q <= 1'b0;
            frames_left_q <= 4'h0;
            idx_q <= {`UPRA_REG_IDX_W{1'b0}};
            prep_q <= 8'h00;
            div_q <= 8'h00;
            bit_q <= 5'h00;
            shreg_q <= {`UPRA_FRAME_BITS{1'b1}};
            upstream_out <= 1'b1;
            rsp_cnt_q <= 8'h00;
            rsp_timeout <= 1'b0;
            ovf_pend_q <= 1'b0;
            read_overflow_flag <= 1'b0;
        end else begin
            if (read_reject && multi_q) begin
                ovf_pend_q <= 1'b1;
            end
            if (stop_cmd) begin
                state_q <= ST_IDLE;
                active_q <= 1'b0;
                multi_q <= 1'b0;
                frames_left_q <= 4'h0;
                upstream_out <= 1'b1;
                ovf_pend_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (accept_read) begin
                            state_q <= ST_WAIT;
                            active_q <= 1'b1;
                            multi_q <= cmd_multi;
                            frames_left_q <= cmd_multi ? cmd_frames : 4'h0;
                            idx_q <= cmd_reg_idx;
                            prep_q <= cmd_multi ? `UPRA_MR_PREP : `UPRA_SR_PREP;
                            rsp_cnt_q <= 8'h00;
                            rsp_timeout <= 1'b0;
                        end
                    end
                    ST_WAIT: begin
                        rsp_cnt_q <= rsp_cnt_q + 8'h01;
                        if (rsp_cnt_q == `UPRA_RSP_CYC) begin
                            rsp_timeout <= 1'b1;
                        end
                        if (link_edge) begin
                            if (prep_q <= 8'h01) begin
                                state_q <= ST_LOAD;
                            end else begin
                                prep_q <= prep_q - 8'h01;
                            end
                        end
                    end
                    ST_LOAD: begin
                        // frame: start, ovf, busy, idx, data, parity, stops
                        shreg_q <= {2'b11, parity, snap_data, idx_q,
                                    read_busy_flag, ovf_pend_q, 1'b0};
                        read_overflow_flag <= ovf_pend_q;
                        // a read dropped in this very cycle stays pending
                        ovf_pend_q <= read_reject & multi_q;
                        // start bit appears together with the enable
                        upstream_out <= 1'b0;
                        div_q <= 8'h00;
                        bit_q <= 5'h00;
                        state_q <= ST_SHIFT;
                    end
                    ST_SHIFT: begin
                        upstream_out <= bit_tick ? shreg_q[1] : shreg_q[0];
                        if (link_edge) begin
                            div_q <= bit_tick ? 8'h00 : div_q + 8'h01;
                        end
                        if (bit_tick) begin
                            shreg_q <= {1'b1, shreg_q[`UPRA_FRAME_BITS-1:1]};
                            bit_q <= bit_q + 5'h01;
                            if (bit_q == `UPRA_FRAME_BITS - 1) begin
                                if (last_frame) begin
                                    state_q <= ST_IDLE;
                                    active_q <= 1'b0;
                                    multi_q <= 1'b0;
                                end else begin
                                    frames_left_q <= frames_left_q - 4'h1;
                                    idx_q <= idx_q + 2'b01;
                                    prep_q <= 8'h01;
                                    state_q <= ST_WAIT;
                                end
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // upra_arbiter

// [core/upra_consts.vh]
// upra_consts.vh: constants of the upstream read arbiter
`ifndef UPRA_CONSTS_VH
`define UPRA_CONSTS_VH
// frame format (bits per upstream frame, start bit first)
`define UPRA_FRAME_BITS 16
`define UPRA_BIT_CNT_W 5
// link clock periods per upstream bit (divider of the sampled link clock)
`define UPRA_BIT_DIV 8'h04
`define UPRA_DIV_W 8
// preparation times in link clock edges
`define UPRA_SR_PREP 8'h08
`define UPRA_MR_PREP 8'h10
// response time in ns, and its cycle count at 40 MHz (rounded down)
`define UPRA_RSP_TIME_NS 2000
`define UPRA_MCLK_NS 25
`define UPRA_RSP_CYC (`UPRA_RSP_TIME_NS / `UPRA_MCLK_NS)
// address bit positions in 16-bit frame
`define UPRA_ADDR_OVF 0
`define UPRA_ADDR_BUSY 1
// upstream-stop bit position in command register 0 data
`define UPRA_STOP_BIT 0
// register contents width
`define UPRA_DATA_W 8
`define UPRA_NREG 4
`define UPRA_REG_IDX_W 2
// reset value of latched register contents
`define UPRA_REG_RST 8'h00
`endif

// [core/upra_snap_mem.v]
// upra_snap_mem.v: small register-content store with registered read data
`timescale 1ns/100ps
`include "upra_consts.vh"
module upra_snap_mem (
    mclk,
    rst,
    wr_en,
    wr_idx,
    wr_data,
    rd_en,
    rd_idx,
    rd_data
);
    input wire mclk;
    input wire rst;
    input wire wr_en;
    input wire [`UPRA_REG_IDX_W-1:0] wr_idx;
    input wire [`UPRA_DATA_W-1:0] wr_data;
    input wire rd_en;
    input wire [`UPRA_REG_IDX_W-1:0] rd_idx;
    output reg [`UPRA_DATA_W-1:0] rd_data;

    reg [`UPRA_DATA_W-1:0] mem_q [0:`UPRA_NREG-1];

    // ==========================================================
    // storage: one write port, registered read
    genvar gi;
    generate
        for (gi = 0; gi < `UPRA_NREG; gi = gi + 1) begin : g_ent
            always @(posedge mclk) begin
                if (rst) begin
                    mem_q[gi] <= `UPRA_REG_RST;
                end else if (wr_en && wr_idx == gi) begin
                    mem_q[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (rst) begin
            rd_data <= `UPRA_REG_RST;
        end else if (rd_en) begin
            rd_data <= mem_q[rd_idx];
        end
    end
endmodule // upra_snap_mem

// [testbench/upra_arbiter_sva.sv]
// upra_arbiter_sva.sv: port assertions of the upstream read arbiter
`timescale 1ns/100ps
module upra_arbiter_sva (
    input wire mclk,
    input wire rst,
    input wire cmd_valid,
    input wire cmd_is_read,
    input wire data_valid,
    input wire write_exec,
    input wire data_exec,
    input wire read_reject,
    input wire upstream_out,
    input wire upstream_oe_n,
    input wire upstream_active,
    input wire read_busy_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_reject_when_busy: assert property (read_reject |-> upstream_active)
        else $error("read dropped while idle");
    a_reject_has_read: assert property (read_reject |-> cmd_valid && cmd_is_read)
        else $error("drop without read");
    a_data_never_blocked: assert property (data_exec == data_valid)
        else $error("data frame blocked");
    a_write_has_cmd: assert property (write_exec |-> cmd_valid && !cmd_is_read)
        else $error("write without command");
    a_shift_when_active: assert property (!upstream_oe_n |-> upstream_active)
        else $error("shifting while idle");
    a_start_bit_low: assert property ($fell(upstream_oe_n) |-> !upstream_out)
        else $error("start bit not low");
    a_idle_level: assert property (upstream_oe_n |-> upstream_out)
        else $error("idle output not high");
    a_reply_in_time: assert property ($rose(upstream_active) |->
        ##[1:170] (!upstream_oe_n || !upstream_active)) else $error("reply late");
    a_frame_held: assert property ($fell(upstream_oe_n) |-> !upstream_oe_n [*8])
        else $error("frame cut short");
    a_busy_in_active: assert property (read_busy_flag |-> upstream_active)
        else $error("busy bit while idle");
endmodule // upra_arbiter_sva

bind upra_arbiter upra_arbiter_sva upra_arbiter_sva_inst (.mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read), .data_valid(data_valid),
    .write_exec(write_exec), .data_exec(data_exec), .read_reject(read_reject),
    .upstream_out(upstream_out), .upstream_oe_n(upstream_oe_n),
    .upstream_active(upstream_active), .read_busy_flag(read_busy_flag));

// [testbench/upra_arbiter_test.sv]
// upra_arbiter_test.sv: self-checking bench of the upstream read arbiter
`timescale 1ns/100ps
module upra_arbiter_test;
    localparam [2:0] WR = 3'b000, RD = 3'b100, MR = 3'b110, ST = 3'b001;
    reg mclk = 0, rst = 1, frame_select_n = 1, link_run = 0, cmd_valid = 0, data_valid = 0;
    reg cmd_is_read = 0, cmd_multi = 0, cmd_is_stop = 0;
    reg [1:0] cmd_reg_idx = 0;
    reg [3:0] cmd_frames = 0;
    reg [7:0] cmd_data = 0, reg_wr_data = 0;
    wire link_clock_pos, write_exec, data_exec, read_reject, upstream_out, upstream_oe_n;
    wire upstream_active, read_overflow_flag, read_busy_flag, rsp_timeout;
    integer n_fail = 0, checked = 0, n_wr = 0, n_rej = 0, cyc = 0, lat = 0, i;
    reg [15:0] f;
    always #12.5 mclk = ~mclk;
    upra_host upra_host_inst (.run(link_run), .link_clock_pos(link_clock_pos));
    upra_arbiter upra_arbiter_inst (.mclk(mclk), .rst(rst), .frame_select_n(frame_select_n),
        .link_clock_pos(link_clock_pos), .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read),
        .cmd_multi(cmd_multi), .cmd_reg_idx(cmd_reg_idx), .cmd_frames(cmd_frames),
        .cmd_is_stop(cmd_is_stop), .cmd_data(cmd_data), .data_valid(data_valid),
        .reg_wr_data(reg_wr_data), .write_exec(write_exec), .data_exec(data_exec),
        .read_reject(read_reject), .upstream_out(upstream_out),
        .upstream_oe_n(upstream_oe_n), .upstream_active(upstream_active),
        .read_overflow_flag(read_overflow_flag), .read_busy_flag(read_busy_flag),
        .rsp_timeout(rsp_timeout));
    always @(posedge mclk) begin
        n_wr <= n_wr + write_exec;
        n_rej <= n_rej + read_reject;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end
    task chk(input [15:0] seen, input [15:0] exp, input string what);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one command frame; taken 3 edges after the select rises
    task cmd(input [2:0] kind, input [1:0] idx, input [3:0] nf, input [7:0] d);
        begin
            @(posedge mclk);
            {cmd_is_read, cmd_multi, cmd_is_stop, cmd_reg_idx, cmd_frames, cmd_data,
                reg_wr_data} <= {kind, idx, nf, d, d};
            frame_select_n <= 1'b0;
            repeat (4) @(posedge mclk);
            frame_select_n <= 1'b1;
            cmd_valid <= 1'b1;
            repeat (5) @(posedge mclk);
            cmd_valid <= 1'b0;
        end
    endtask
    // samples mid-bit, 4 link periods of 8 mclk each per bit
    task get_frame;
        integer b;
        begin
            for (i = 0; i < 300 && upstream_oe_n; i = i + 1) @(posedge mclk);
            lat = i;
            if (i > 0) repeat (16) @(posedge mclk);
            for (b = 0; b < 16; b = b + 1) begin
                f[b] = upstream_out;
                repeat (32) @(posedge mclk);
            end
        end
    endtask
    task idle;
        for (i = 0; i < 2000 && upstream_active; i = i + 1) @(posedge mclk);
    endtask
    task t_single;
        integer w, r;
        begin
            cmd(WR, 2'h1, 4'h0, 8'h5a);
            cmd(RD, 2'h1, 4'h0, 8'h00);
            w = n_wr;
            r = n_rej;
            cmd(WR, 2'h1, 4'h0, 8'ha5);
            chk(n_wr - w, 0, "prep write");
            fork
                get_frame;
                begin
                    repeat (140) @(posedge mclk);
                    cmd(WR, 2'h1, 4'h0, 8'h3c);
                    cmd(RD, 2'h2, 4'h0, 8'h00);
                    data_valid <= 1'b1;
                    @(posedge mclk);
                    chk(data_exec, 1, "data exec");
                    data_valid <= 1'b0;
                end
            join
            chk(lat + 15 <= 80, 1, "response");
            chk(rsp_timeout, 0, "timeout");
            chk({f[15:3], f[0]}, {2'b11, ^8'h5a, 8'h5a, 2'h1, 1'b0}, "frame");
            chk(f[2:1], 2'b00, "single flags");
            chk(n_wr - w, 1, "late write");
            chk(n_rej - r, 1, "busy read");
            idle;
            cmd(RD, 2'h1, 4'h0, 8'h00);
            get_frame;
            chk(f[12:5], 8'h3c, "new read");
            chk(n_rej - r, 1, "read after stop bit");
            $display("t_single done");
        end
    endtask
    task t_multi;
        integer r;
        begin
            idle;
            r = n_rej;
            cmd(MR, 2'h0, 4'h1, 8'h00);
            fork
                get_frame;
                begin
                    repeat (200) @(posedge mclk);
                    cmd(RD, 2'h0, 4'h0, 8'h00);
                end
            join
            chk(f[2:1], 2'b10, "first flags");
            get_frame;
            chk({f[12:3], f[2:1]}, {8'h3c, 2'h1, 2'b01}, "last frame");
            chk(n_rej - r, 1, "multi drop");
            chk(read_overflow_flag, 1, "ovf output");
            idle;
            cmd(MR, 2'h0, 4'h3, 8'h00);
            for (i = 0; i < 300 && upstream_oe_n; i = i + 1) @(posedge mclk);
            repeat (50) @(posedge mclk);
            cmd(ST, 2'h0, 4'h0, 8'h01);
            chk({upstream_active, upstream_oe_n}, 2'b01, "stopped");
            cmd(RD, 2'h1, 4'h0, 8'h00);
            chk(upstream_active, 1, "read after stop");
            chk(n_rej - r, 1, "no drop after stop");
            idle;
            $display("t_multi done");
        end
    endtask
    task tally_and_finish;
        begin
            $display("checked %0d n_fail %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        link_run <= 1'b1;
        repeat (3) @(posedge mclk);
        t_single;
        t_multi;
        link_run <= 1'b0;
        tally_and_finish;
    end
endmodule // upra_arbiter_test

// [testbench/upra_host.sv]
// upra_host.sv: host side link clock of the serial control channel
`timescale 1ns/100ps
module upra_host (
    input wire run,
    output reg link_clock_pos
);
    // 200 ns period, stands low when not run
    initial begin
        link_clock_pos = 1'b0;
        #37;
        forever begin
            #100;
            link_clock_pos = run ? ~link_clock_pos : 1'b0;
        end
    end
endmodule // upra_host
